// *** core/trip_retry_defines.svh ***
// Constants for the trip retry controller.
`ifndef TRIP_RETRY_DEFINES_SVH
`define TRIP_RETRY_DEFINES_SVH
// ---------------------------------------------------------------------------
// Register offsets (word addresses, one word each)
// ---------------------------------------------------------------------------
`define TR_OFS_CLASS    4'h0
`define TR_OFS_LIMIT    4'h1
`define TR_OFS_WAIT     4'h2
`define TR_OFS_COUNT    4'h3
`define TR_OFS_STATUS   4'h4
`define TR_OFS_MASK     4'h5
`define TR_OFS_FAULT    4'h6
`define TR_OFS_RANGE    4'h7
// ---------------------------------------------------------------------------
// Setting limits and codes
// ---------------------------------------------------------------------------
`define TR_CLASS_MAX    8'h05
`define TR_LIMIT_MAX    8'h0a
`define TR_ALARM_BASE   8'h64
`define TR_ALARM_MAX    8'h6e
`define TR_WAIT_MAX_DS  8'h64
`define TR_RANGE_SHOWN  16'h270f
`define TR_CODE_RET     5'h0f
`define TR_SUCCESS_MUL  3'h4
// Tenth of a second in clock cycles at 10 MHz.
`define TR_CLK_HZ       1000000_0
`define TR_DS_CYCLES    (`TR_CLK_HZ / 10)
// ---------------------------------------------------------------------------
// Interrupt bit positions
// ---------------------------------------------------------------------------
`define TR_IRQ_TRIP     0
`define TR_IRQ_RESTART  1
`define TR_IRQ_SUCCESS  2
`define TR_IRQ_EXCEED   3
`define TR_IRQ_W        4
`endif

// *** core/trip_retry_pkg.sv ***
// Types shared by the trip retry controller.
package trip_retry_pkg;
  typedef enum logic [2:0] {
    ST_RUN, ST_WAIT, ST_WATCH, ST_LOCKED
  } retry_state_e;
  typedef logic [4:0] fault_code_t;
endpackage

// *** core/trip_retry_controller.sv ***
// Automatic trip-recovery controller with an Avalon-MM register slave.
`include "trip_retry_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module trip_retry_controller
  import trip_retry_pkg::*;
#(
  parameter int DS_CYCLES = `TR_DS_CYCLES  // Cycles per tenth of a second.
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        por_i,          // Power-on reset.
  // Avalon-MM slave.
  input  wire logic [3:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  output logic      [1:0]  response_o,
  // Fault detector side.
  input  wire logic        trip_i,         // One-cycle trip event.
  input  wire logic [4:0]  trip_code_i,    // Code of the trip.
  // Drive side.
  output logic             trip_reset_o,   // One-cycle trip reset pulse.
  output logic             restart_o,      // One-cycle restart pulse.
  output logic             tripped_o,      // Drive held tripped.
  output logic             alarm_o,        // Alarm output.
  output logic             thermal_clr_o,  // Clear thermal memory.
  // Displays.
  output logic      [4:0]  local_code_o,   // Local indicator code.
  output logic      [4:0]  panel_code_o,   // Operator panel code.
  output logic             irq_o
);
  // -------------------------------------------------------------------------
  // Parameter check
  // -------------------------------------------------------------------------
  if (DS_CYCLES < 1) begin : g_chk
    $error("DS_CYCLES must be at least one.");
  end

  // -------------------------------------------------------------------------
  // Decoding functions
  // -------------------------------------------------------------------------
  // Table of trip codes retried for each class selection.
  function automatic logic eligible(input logic [2:0] cls,
                                    input fault_code_t code);
    logic [17:0] m;
    m = 18'h0;
    case (cls)
      3'd0:    m = 18'h305c1;
      3'd1:    m = 18'h00007;
      3'd2:    m = 18'h00208;
      3'd3:    m = 18'h0003a;
      3'd4:    m = 18'h20f7b;
      3'd5:    m = 18'h08005;
      default: m = 18'h0;
    endcase
    eligible = (code < 5'd18) ? m[code] : 1'b0;
  endfunction

  // Number of retries allowed by a limit setting.
  function automatic logic [3:0] allowed(input logic [7:0] lim);
    if (lim >= `TR_ALARM_BASE + 8'h1) begin
      allowed = 4'(lim - `TR_ALARM_BASE);
    end else begin
      allowed = 4'(lim);
    end
  endfunction

  // Legal values of the limit setting.
  function automatic logic limit_ok(input logic [7:0] v);
    limit_ok = (v <= `TR_LIMIT_MAX) ||
               (v > `TR_ALARM_BASE && v <= `TR_ALARM_MAX);
  endfunction

  // -------------------------------------------------------------------------
  // Registers and state
  // -------------------------------------------------------------------------
  logic [2:0]          class_q;      // Retry class selection.
  logic [7:0]          limit_q;      // Retry attempt limit.
  logic [7:0]          wait_q;       // Wait in tenths of a second.
  logic [15:0]         count_q;      // Cumulative successful retries.
  logic [`TR_IRQ_W-1:0] status_q;    // Sticky event bits.
  logic [`TR_IRQ_W-1:0] mask_q;      // Interrupt enables.
  retry_state_e        state_q;      // Sequencer state.
  logic [3:0]          tries_q;      // Retries made in this episode.
  logic [10:0]         ds_q;         // Tenths elapsed.
  logic [31:0]         tick_q;       // Cycle prescaler.
  fault_code_t         record_q;     // Stored fault record.
  logic                acc;          // Bus access this cycle.
  logic                wr_ok;        // Write committed at acknowledge.
  logic [`TR_IRQ_W-1:0] ev;          // Events this cycle.
  logic                succ;         // Retry judged successful.
  logic                tick;         // Tenth of a second elapsed.

  assign acc   = (read_i | write_i) & waitrequest_o;
  // A write lands only at the edge where the master sees waitrequest low.
  assign wr_ok = write_i & !waitrequest_o;
  assign tick  = (tick_q == 32'(DS_CYCLES - 1));
  assign succ  = (state_q == ST_WATCH) && !trip_i &&
                 (ds_q >= 11'(wait_q) * 11'(`TR_SUCCESS_MUL));

  // -------------------------------------------------------------------------
  // Avalon handshake: one wait state, then answer
  // -------------------------------------------------------------------------
  // Waitrequest drops for one cycle after each request is seen.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      waitrequest_o <= 1'b1;
    end else begin
      waitrequest_o <= !((read_i | write_i) && waitrequest_o);
    end
  end

  // Read data and response are prepared while waitrequest is high.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      readdata_o <= 32'h0;
      response_o <= 2'h0;
    end else if (acc) begin
      response_o <= (address_i > `TR_OFS_RANGE) ? 2'h2 : 2'h0;
      case (address_i)
        `TR_OFS_CLASS:  readdata_o <= {29'h0, class_q};
        `TR_OFS_LIMIT:  readdata_o <= {24'h0, limit_q};
        `TR_OFS_WAIT:   readdata_o <= {24'h0, wait_q};
        `TR_OFS_COUNT:  readdata_o <= {16'h0, count_q};
        `TR_OFS_STATUS: readdata_o <= {28'h0, status_q};
        `TR_OFS_MASK:   readdata_o <= {28'h0, mask_q};
        `TR_OFS_FAULT:  readdata_o <= {27'h0, record_q};
        // Panel range shows 0..10 and 9999; alarm codes hidden.
        `TR_OFS_RANGE:  readdata_o <= {`TR_RANGE_SHOWN,
                                       8'h0, `TR_LIMIT_MAX};
        default:        readdata_o <= 32'h0;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Settings
  // -------------------------------------------------------------------------
  // Out-of-range values are ignored (class and wait judge bits 7:0 only); alarm codes accepted though hidden.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      class_q <= 3'h0;
      limit_q <= 8'h0;
      wait_q  <= 8'h0;
      mask_q  <= '0;
    end else if (wr_ok) begin
      case (address_i)
        `TR_OFS_CLASS: begin
          if (writedata_i[7:0] <= `TR_CLASS_MAX) begin
            class_q <= writedata_i[2:0];
          end
        end
        `TR_OFS_LIMIT: begin
          if (writedata_i[31:8] == 24'h0 &&
              limit_ok(writedata_i[7:0])) begin
            limit_q <= writedata_i[7:0];
          end
        end
        `TR_OFS_WAIT: begin
          if (writedata_i[7:0] <= `TR_WAIT_MAX_DS) begin
            wait_q <= writedata_i[7:0];
          end
        end
        `TR_OFS_MASK: mask_q <= writedata_i[`TR_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Success counter
  // -------------------------------------------------------------------------
  // A clear write and a success in the same cycle leave a count of one.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      count_q <= 16'h0;
    end else if (wr_ok && address_i == `TR_OFS_COUNT &&
                 writedata_i == 32'h0) begin
      count_q <= {15'h0, succ};
    end else if (succ && count_q != 16'hffff) begin
      count_q <= count_q + 16'h1;
    end
  end

  // -------------------------------------------------------------------------
  // Time base
  // -------------------------------------------------------------------------
  // Prescaler and tenth-second counter restart at every trip.
  always_ff @(posedge clk_i) begin
    if (srst_i || trip_i || state_q == ST_RUN || state_q == ST_LOCKED) begin
      tick_q <= 32'h0;
      ds_q   <= 11'h0;
    end else if (tick) begin
      tick_q <= 32'h0;
      ds_q   <= (ds_q == 11'h7ff) ? ds_q : ds_q + 11'h1;
    end else begin
      tick_q <= tick_q + 32'h1;
    end
  end

  // -------------------------------------------------------------------------
  // Retry sequencer
  // -------------------------------------------------------------------------
  // Runs wait, restart and watch; locks when retries are exhausted.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q      <= ST_RUN;
      tries_q      <= 4'h0;
      trip_reset_o <= 1'b0;
      restart_o    <= 1'b0;
      tripped_o    <= 1'b0;
      alarm_o      <= 1'b0;
      local_code_o <= '0;
      panel_code_o <= '0;
      record_q     <= '0;
    end else begin
      trip_reset_o <= 1'b0;
      restart_o    <= 1'b0;
      if (trip_i) begin
        local_code_o <= trip_code_i;
        tripped_o    <= 1'b1;
        if (state_q != ST_WATCH) begin
          panel_code_o <= trip_code_i;
          record_q     <= trip_code_i;
        end
        if (state_q == ST_LOCKED) begin
          state_q <= ST_LOCKED;
        end else if (allowed(limit_q) == 4'h0 ||
                     !eligible(class_q, trip_code_i)) begin
          state_q <= ST_LOCKED;
          alarm_o <= 1'b1;
        end else if (tries_q >= allowed(limit_q)) begin
          state_q      <= ST_LOCKED;
          alarm_o      <= 1'b1;
          // The record keeps the first-retry alarm, not the exceeded code.
          local_code_o <= `TR_CODE_RET;
        end else begin
          state_q <= ST_WAIT;
          alarm_o <= (limit_q > `TR_ALARM_BASE);
        end
      end else begin
        case (state_q)
          ST_WAIT: begin
            if (ds_q >= 11'(wait_q)) begin
              // Trip reset only; thermal memory is kept.
              trip_reset_o <= 1'b1;
              restart_o    <= 1'b1;
              tripped_o    <= 1'b0;
              alarm_o      <= 1'b0;
              tries_q      <= tries_q + 4'h1;
              state_q      <= ST_WATCH;
            end
          end
          ST_WATCH: begin
            if (succ) begin
              tries_q <= 4'h0;
              state_q <= ST_RUN;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // -------------------------------------------------------------------------
  // Thermal memory clear
  // -------------------------------------------------------------------------
  // Only power-on reset clears the thermal data, never a retry.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      thermal_clr_o <= 1'b0;
    end else begin
      thermal_clr_o <= por_i;
    end
  end

  // -------------------------------------------------------------------------
  // Interrupts
  // -------------------------------------------------------------------------
  assign ev[`TR_IRQ_TRIP]    = trip_i;
  assign ev[`TR_IRQ_RESTART] = (state_q == ST_WAIT) && !trip_i &&
                               (ds_q >= 11'(wait_q));
  assign ev[`TR_IRQ_SUCCESS] = succ;
  assign ev[`TR_IRQ_EXCEED]  = trip_i && state_q != ST_LOCKED &&
                               allowed(limit_q) != 4'h0 &&
                               eligible(class_q, trip_code_i) &&
                               tries_q >= allowed(limit_q);

  // Sticky status, write one to clear; a new event wins over the clear.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      status_q <= '0;
    end else if (wr_ok && address_i == `TR_OFS_STATUS) begin
      status_q <= (status_q & ~writedata_i[`TR_IRQ_W-1:0]) | ev;
    end else begin
      status_q <= status_q | ev;
    end
  end

  // Interrupt level from the masked status.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_q & mask_q);
    end
  end
endmodule
`default_nettype wire

// *** bench/trip_retry_chk.sv ***
// Port checker for the trip retry controller.
`include "trip_retry_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module trip_retry_chk (
  // Clock, reset and bus.
  input wire logic       clk_i,
  input wire logic       srst_i,
  input wire logic       por_i,
  input wire logic [3:0] address_i,
  input wire logic       read_i,
  input wire logic       write_i,
  input wire logic       waitrequest_o,
  input wire logic [1:0] response_o,
  // Fault and drive side.
  input wire logic       trip_i,
  input wire logic [4:0] trip_code_i,
  input wire logic       trip_reset_o,
  input wire logic       restart_o,
  input wire logic       tripped_o,
  input wire logic       alarm_o,
  input wire logic       thermal_clr_o,
  input wire logic [4:0] local_code_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // A taken request is answered in the next cycle, for one cycle only.
  bus_answer_a: assert property ((read_i || write_i) && waitrequest_o
    |=> !waitrequest_o) else $error("Bus request not answered");
  answer_pulse_a: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("Answer held too long");
  unmapped_resp_a: assert property ((read_i || write_i) && waitrequest_o
    && address_i[3] |=> response_o == 2'h2) else $error("Bad response");
  // A retry resets the trip and restarts in the same cycle.
  restart_pair_a: assert property (trip_reset_o == restart_o)
    else $error("Reset and restart apart");
  restart_run_a: assert property (restart_o && !trip_i |=> !tripped_o)
    else $error("Still tripped after restart");
  trip_hold_a: assert property (trip_i |=> tripped_o)
    else $error("Trip not held");
  local_code_a: assert property (trip_i |=> local_code_o ==
    $past(trip_code_i) || local_code_o == `TR_CODE_RET)
    else $error("Local code wrong");
  alarm_trip_a: assert property (alarm_o |-> tripped_o)
    else $error("Alarm while running");
  // Thermal memory is cleared by power-on only.
  thermal_por_a: assert property (thermal_clr_o |-> $past(por_i))
    else $error("Thermal cleared without power-on");
endmodule
`default_nettype wire

// *** bench/fault_source.sv ***
// Fault detector model that raises trip events.
`timescale 1ns/1ns
`default_nettype none
module fault_source (
  // Clock and trip link.
  input  wire logic       clk_i,
  output logic            trip_o,
  output logic      [4:0] code_o
);
  initial begin
    trip_o = 1'b0;
    code_o = 5'h1f;
  end
  // One-cycle trip event; the code is not held afterwards.
  task automatic fire(input logic [4:0] code);
    @(posedge clk_i);
    trip_o <= 1'b1;
    code_o <= code;
    @(posedge clk_i);
    trip_o <= 1'b0;
    code_o <= ~code;
  endtask
endmodule
`default_nettype wire

// *** bench/trip_retry_controller_tb.sv ***
// Self-checking testbench for the trip retry controller.
`include "trip_retry_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module trip_retry_controller_tb;
  import trip_retry_pkg::*;
  localparam int DS = 4;  // Cycles per tenth of a second here.
  logic        clk_i, srst_i, por_i, read_i, write_i, waitrequest_o;
  logic        trip_i, trip_reset_o, restart_o, tripped_o, alarm_o;
  logic        thermal_clr_o, irq_o;
  logic [3:0]  address_i;
  logic [31:0] writedata_i, readdata_o, rd;
  logic [1:0]  response_o, rsp;
  logic [4:0]  trip_code_i, local_code_o, panel_code_o;
  int          error_cnt, num_checks, cyc;
  trip_retry_controller #(.DS_CYCLES(DS)) trip_retry_controller_inst (
    .clk_i, .srst_i, .por_i, .address_i, .read_i, .write_i, .writedata_i,
    .readdata_o, .waitrequest_o, .response_o, .trip_i, .trip_code_i,
    .trip_reset_o, .restart_o, .tripped_o, .alarm_o, .thermal_clr_o,
    .local_code_o, .panel_code_o, .irq_o);
  fault_source fault_source_inst (.clk_i, .trip_o(trip_i),
    .code_o(trip_code_i));
  // ---------------------------------------------------------------
  // Common tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("Checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task automatic chk_bit(input logic got, exp, input string m);
    chk_word({31'h0, got}, {31'h0, exp}, m);
  endtask
  // One Avalon access; held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    read_i <= !wr;
    write_i <= wr;
    address_i <= a;
    writedata_i <= d;
    do @(posedge clk_i); while (waitrequest_o !== 1'b0);
    rd = readdata_o;
    rsp = response_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask
  task automatic do_reset();
    srst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
  endtask
  task automatic cfg(input logic [31:0] c, l, w);
    bus(1'b1, `TR_OFS_CLASS, c);
    bus(1'b1, `TR_OFS_LIMIT, l);
    bus(1'b1, `TR_OFS_WAIT, w);
  endtask
  // Waits for a restart pulse for at most mx cycles.
  task automatic wait_restart(output int n, input int mx);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (restart_o !== 1'b1 && n < mx);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    bus(1'b0, `TR_OFS_RANGE, 32'h0);
    chk_word(rd, {`TR_RANGE_SHOWN, 8'h00, `TR_LIMIT_MAX}, "range");
    bus(1'b0, 4'h9, 32'h0);
    chk_word({30'h0, rsp}, 32'h2, "unmapped");
    bus(1'b1, `TR_OFS_CLASS, 32'h6);
    bus(1'b0, `TR_OFS_CLASS, 32'h0);
    chk_word(rd, 32'h0, "class refused");
    bus(1'b1, `TR_OFS_LIMIT, 32'h65);
    bus(1'b1, `TR_OFS_LIMIT, 32'hb);
    bus(1'b0, `TR_OFS_LIMIT, 32'h0);
    chk_word(rd, 32'h65, "limit codes");
  endtask
  task automatic t_retry_ok();
    int n;
    cfg(32'h0, 32'h1, 32'h2);
    fault_source_inst.fire(5'h00);
    wait_restart(n, 60);
    chk_bit(n >= 2*DS-1 && n <= 2*DS+4, 1'b1, "wait");
    chk_bit(alarm_o, 1'b0, "alarm");
    bus(1'b0, `TR_OFS_COUNT, 32'h0);
    chk_word(rd, 32'h0, "count early");
    repeat (8*DS) @(posedge clk_i);
    bus(1'b0, `TR_OFS_COUNT, 32'h0);
    chk_word(rd, 32'h1, "count");
    chk_bit(irq_o, 1'b0, "irq masked");
    bus(1'b1, `TR_OFS_MASK, 32'h1 << `TR_IRQ_SUCCESS);
    repeat (2) @(posedge clk_i);
    chk_bit(irq_o, 1'b1, "irq raised");
    bus(1'b1, `TR_OFS_STATUS, 32'hf);
    repeat (2) @(posedge clk_i);
    chk_bit(irq_o, 1'b0, "irq cleared");
    bus(1'b1, `TR_OFS_COUNT, 32'h0);
    bus(1'b0, `TR_OFS_COUNT, 32'h0);
    chk_word(rd, 32'h0, "count clear");
  endtask
  task automatic t_limit();
    int n;
    cfg(32'h0, 32'h66, 32'h1);
    fault_source_inst.fire(5'h06);
    repeat (2) @(posedge clk_i);
    chk_bit(alarm_o, 1'b1, "alarm in wait");
    wait_restart(n, 40);
    fault_source_inst.fire(5'h07);
    repeat (2) @(posedge clk_i);
    chk_word({27'h0, local_code_o}, 32'h7, "local newest");
    chk_word({27'h0, panel_code_o}, 32'h6, "panel first");
    wait_restart(n, 40);
    fault_source_inst.fire(5'h00);
    wait_restart(n, 12*DS);
    chk_bit(restart_o, 1'b0, "retry past limit");
    chk_bit(tripped_o, 1'b1, "held tripped");
    chk_word({27'h0, local_code_o}, {27'h0, `TR_CODE_RET}, "code");
    bus(1'b0, `TR_OFS_FAULT, 32'h0);
    chk_word(rd, 32'h6, "record");
    do_reset();
  endtask
  task automatic t_ineligible();
    int n;
    cfg(32'h1, 32'ha, 32'h0);
    fault_source_inst.fire(5'h02);
    wait_restart(n, 20);
    chk_bit(restart_o, 1'b1, "eligible");
    repeat (4) @(posedge clk_i);
    fault_source_inst.fire(5'h03);
    wait_restart(n, 20);
    chk_bit(restart_o, 1'b0, "not eligible");
    chk_bit(tripped_o, 1'b1, "locked");
    do_reset();
  endtask
  // One trip under a class selection; exp says whether it is retried.
  task automatic try_class(input logic [2:0] c, input logic [4:0] code,
                           input logic exp);
    int n;
    do_reset();
    cfg({29'h0, c}, 32'ha, 32'h0);
    fault_source_inst.fire(code);
    wait_restart(n, 6);
    chk_bit(restart_o, exp, "class table");
  endtask
  task automatic t_classes();
    try_class(3'h0, 5'h08, 1'b1);
    try_class(3'h0, 5'h09, 1'b0);
    try_class(3'h4, 5'h01, 1'b1);
    try_class(3'h4, 5'h07, 1'b0);
    try_class(3'h5, 5'h0f, 1'b1);
    try_class(3'h2, 5'h09, 1'b1);
    do_reset();
  endtask
  task automatic t_por();
    @(posedge clk_i);
    por_i <= 1'b1;
    @(posedge clk_i);
    por_i <= 1'b0;
    @(posedge clk_i);
    chk_bit(thermal_clr_o, 1'b1, "power-on clear");
  endtask
  // ---------------------------------------------------------------
  // Clock, timeout and main sequence
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // A hang past the expected run length ends the test.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      $display("Error at %0t: timeout", $time);
      end_of_test();
    end
  end
  initial begin
    por_i = 1'b0;
    read_i = 1'b0;
    write_i = 1'b0;
    address_i = 4'h0;
    writedata_i = 32'h0;
    do_reset();
    t_regs();
    t_retry_ok();
    t_limit();
    t_ineligible();
    t_classes();
    t_por();
    end_of_test();
  end
endmodule
bind trip_retry_controller trip_retry_chk trip_retry_chk_inst (
  .clk_i, .srst_i, .por_i, .address_i, .read_i, .write_i, .waitrequest_o,
  .response_o, .trip_i, .trip_code_i, .trip_reset_o, .restart_o,
  .tripped_o, .alarm_o, .thermal_clr_o, .local_code_o);
`default_nettype wire
